// ### hw/t16_regs.svh
// Register offsets, field positions, reset values and mode codes of the 16-bit timer.
`ifndef T16_REGS_SVH
`define T16_REGS_SVH

`define T16_ADDR_W 6
`define T16_OFF_CTRL_A 6'h00
`define T16_OFF_CTRL_B 6'h04
`define T16_OFF_COUNT_LO 6'h08
`define T16_OFF_COUNT_HI 6'h0C
`define T16_OFF_CAPT_LO 6'h10
`define T16_OFF_CAPT_HI 6'h14
`define T16_OFF_FLAG 6'h18
`define T16_OFF_MASK 6'h1C
`define T16_OFF_COMP_CS 6'h20

`define T16_BYTE 7:0
`define T16_WGML_RNG 1:0
`define T16_CS_RNG 2:0
`define T16_WGMH_RNG 4:3
`define T16_EDGE_BIT 6
`define T16_NF_BIT 7
`define T16_OVF_BIT 0
`define T16_CAP_BIT 5
`define T16_COMPARATOR_CAPTURE_SELECT_BIT 2
`define T16_STRB_LO 0

`define T16_CS_STOP 3'h0
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7

`define T16_PRE_W 10
`define T16_PRE_M8 10'h007
`define T16_PRE_M64 10'h03F
`define T16_PRE_M256 10'h0FF
`define T16_PRE_M1024 10'h3FF
`define T16_PRE_ONE 10'h001

`define T16_WGM_NORMAL 4'h0
`define T16_WGM_PC8 4'h1
`define T16_WGM_PC9 4'h2
`define T16_WGM_PC10 4'h3
`define T16_WGM_CTC_A 4'h4
`define T16_WGM_FP8 4'h5
`define T16_WGM_FP9 4'h6
`define T16_WGM_FP10 4'h7
`define T16_WGM_PFC_ICR 4'h8
`define T16_WGM_PFC_A 4'h9
`define T16_WGM_PC_ICR 4'hA
`define T16_WGM_PC_A 4'hB
`define T16_WGM_CTC_ICR 4'hC
`define T16_WGM_FP_ICR 4'hE
`define T16_WGM_FP_A 4'hF

`define T16_MAX 16'hFFFF
`define T16_BOTTOM 16'h0000
`define T16_TOP8 16'h00FF
`define T16_TOP9 16'h01FF
`define T16_TOP10 16'h03FF
`define T16_ONE 16'h0001

`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000
`define T16_RST_DATA 32'h00000000
`define T16_RESP_OKAY 2'h0
`define T16_RESP_SLVERR 2'h2
`define T16_FILT_N 4

`endif

// ### hw/t16_pkg.sv
// Types shared by the 16-bit timer modules.
package t16_pkg;

  typedef logic [3:0] t16_wgm_t;

  // Control register B fields as software sees them.
  typedef struct packed {
    logic noise_en;
    logic edge_rise;
    logic [1:0] wgm_hi;
    logic [2:0] clk_sel;
  } t16_ctrlb_t;

  // Sticky event flags.
  typedef struct packed {
    logic capture;
    logic overflow;
  } t16_flags_t;

  // Pending write held by the bus slave.
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] data;
    logic strb_lo;
  } t16_wreq_t;

endpackage

// ### hw/t16_trig_sync.sv
// Pin sampler, optional four-sample noise filter and edge detector.
`timescale 1ns/10ps
`default_nettype none
`include "t16_regs.svh"

module t16_trig_sync
  import t16_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic filter_en_i,
  input wire logic rising_i,
  input wire logic enable_i,
  // Signal
  input wire logic raw_i,
  output logic level_o,
  output logic edge_o
);

  logic s1_q, s2_q, s3_q;
  logic lvl_q;
  logic [`T16_FILT_N-2:0] hist_q;
  logic filt_q;
  logic prev_q;
  logic edge_q;
  logic out_lvl;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  // Output moves only when all four samples agree; costs four cycles.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[`T16_FILT_N-3:0], lvl_q};
      if (&{hist_q, lvl_q}) begin
        filt_q <= 1'b1;
      end else if (~|{hist_q, lvl_q}) begin
        filt_q <= 1'b0;
      end
    end
  end

  assign out_lvl = filter_en_i ? filt_q : lvl_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      prev_q <= out_lvl;
      edge_q <= enable_i & (rising_i ? (out_lvl & ~prev_q) : (~out_lvl & prev_q));
    end
  end

  assign level_o = out_lvl;
  assign edge_o = edge_q;

endmodule // t16_trig_sync

`default_nettype wire

// ### hw/t16_timer.sv
// 16-bit timer/counter with input capture and an AXI4-Lite register slave.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "t16_regs.svh"

// Function
// - Clock select field picks timer clock
// - Counter has count, direction, clear, top, bottom
// - Count upper byte goes through holding register
// - Each timer clock clears, increments or decrements
// - Select zero stops; access still works
// - Software count write beats clear and count
// - Four-bit waveform mode split across A and B
// - Overflow flag set per mode, requests interrupt
// - Selected trigger edge copies count to capture
// - Capture flag set with the copy
// - Enabled capture flag interrupts; ack or one clears
// - Capture lower byte read loads holding register
// - Capture writable only in capture-top modes
// - Comparator select routes comparator as trigger
// - Trigger sampled like the external clock pin
// - Filter changes only when four samples agree
// - Filter adds four system cycles, system clock
// - Trigger path disabled in capture-top modes
// - Port-driven pin level also triggers capture
// - New capture overwrites unread value
// - One holding register shared by all words
// - Lower byte write loads whole word at once
module t16_timer
  import t16_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [`T16_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [`T16_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Pins
  input wire logic external_clock_pin_i,
  input wire logic capture_pin_i,
  input wire logic comparator_output_i,
  // Interrupt requests and their execution acknowledges
  output logic overflow_irq_o,
  input wire logic overflow_irq_ack_i,
  output logic capture_irq_o,
  input wire logic capture_irq_ack_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0] wgm_lo_q;
  t16_ctrlb_t ctrlb_q;
  logic [15:0] count_q;
  logic [15:0] capt_q;
  logic [7:0] temp_q;
  t16_flags_t flags_q;
  t16_flags_t mask_q;
  logic comparator_capture_select_q;
  logic dir_down_q;
  logic [`T16_PRE_W-1:0] pre_q;

  t16_wgm_t wgm;
  assign wgm = {ctrlb_q.wgm_hi, wgm_lo_q};

  // True for the modes in which the capture register sets the ceiling.
  function automatic logic capt_is_top(input t16_wgm_t m);
    capt_is_top = (m == `T16_WGM_PFC_ICR) || (m == `T16_WGM_PC_ICR) ||
                  (m == `T16_WGM_CTC_ICR) || (m == `T16_WGM_FP_ICR);
  endfunction

  function automatic logic dual_slope(input t16_wgm_t m);
    dual_slope = (m == `T16_WGM_PC8) || (m == `T16_WGM_PC9) || (m == `T16_WGM_PC10) ||
                 (m == `T16_WGM_PFC_ICR) || (m == `T16_WGM_PFC_A) ||
                 (m == `T16_WGM_PC_ICR) || (m == `T16_WGM_PC_A);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  t16_wreq_t wreq_q;
  logic aw_full_q, w_full_q, bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_wr, do_rd;
  logic wr_lo;
  logic [7:0] wbyte;

  assign s_axi_awready_o = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready_o = ~w_full_q & ~bvalid_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign do_rd = s_axi_arvalid_i & ~rvalid_q;
  assign wr_lo = do_wr & wreq_q.strb_lo;
  assign wbyte = wreq_q.data[`T16_BYTE];

  function automatic logic mapped(input logic [`T16_ADDR_W-1:0] a);
    case (a)
      `T16_OFF_CTRL_A, `T16_OFF_CTRL_B, `T16_OFF_COUNT_LO, `T16_OFF_COUNT_HI,
      `T16_OFF_CAPT_LO, `T16_OFF_CAPT_HI, `T16_OFF_FLAG, `T16_OFF_MASK,
      `T16_OFF_COMP_CS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Address and data are taken in either order and held until both are in.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wreq_q <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_q <= 1'b1;
        wreq_q.addr <= s_axi_awaddr_i;
      end else if (do_wr) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_q <= 1'b1;
        wreq_q.data <= s_axi_wdata_i;
        wreq_q.strb_lo <= s_axi_wstrb_i[`T16_STRB_LO];
      end else if (do_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `T16_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(wreq_q.addr) ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Upper-byte locations return the holding register, not the live word.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= `T16_RST_DATA;
      rresp_q <= `T16_RESP_OKAY;
    end else if (do_rd) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr_i) ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
      rdata_q <= `T16_RST_DATA;
      case (s_axi_araddr_i)
        `T16_OFF_CTRL_A: rdata_q[`T16_WGML_RNG] <= wgm_lo_q;
        `T16_OFF_CTRL_B: begin
          rdata_q[`T16_CS_RNG] <= ctrlb_q.clk_sel;
          rdata_q[`T16_WGMH_RNG] <= ctrlb_q.wgm_hi;
          rdata_q[`T16_EDGE_BIT] <= ctrlb_q.edge_rise;
          rdata_q[`T16_NF_BIT] <= ctrlb_q.noise_en;
        end
        `T16_OFF_COUNT_LO: rdata_q[`T16_BYTE] <= count_q[`T16_BYTE];
        `T16_OFF_CAPT_LO: rdata_q[`T16_BYTE] <= capt_q[`T16_BYTE];
        `T16_OFF_COUNT_HI, `T16_OFF_CAPT_HI: rdata_q[`T16_BYTE] <= temp_q;
        `T16_OFF_FLAG: begin
          rdata_q[`T16_OVF_BIT] <= flags_q.overflow;
          rdata_q[`T16_CAP_BIT] <= flags_q.capture;
        end
        `T16_OFF_MASK: begin
          rdata_q[`T16_OVF_BIT] <= mask_q.overflow;
          rdata_q[`T16_CAP_BIT] <= mask_q.capture;
        end
        `T16_OFF_COMP_CS: rdata_q[`T16_COMPARATOR_CAPTURE_SELECT_BIT] <= comparator_capture_select_q;
        default: rdata_q <= `T16_RST_DATA;
      endcase
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wgm_lo_q <= '0;
      ctrlb_q <= '0;
      mask_q <= '0;
      comparator_capture_select_q <= 1'b0;
    end else if (wr_lo) begin
      case (wreq_q.addr)
        `T16_OFF_CTRL_A: wgm_lo_q <= wbyte[`T16_WGML_RNG];
        `T16_OFF_CTRL_B: begin
          ctrlb_q.clk_sel <= wbyte[`T16_CS_RNG];
          ctrlb_q.wgm_hi <= wbyte[`T16_WGMH_RNG];
          ctrlb_q.edge_rise <= wbyte[`T16_EDGE_BIT];
          ctrlb_q.noise_en <= wbyte[`T16_NF_BIT];
        end
        `T16_OFF_MASK: begin
          mask_q.overflow <= wbyte[`T16_OVF_BIT];
          mask_q.capture <= wbyte[`T16_CAP_BIT];
        end
        `T16_OFF_COMP_CS: comparator_capture_select_q <= wbyte[`T16_COMPARATOR_CAPTURE_SELECT_BIT];
        default: comparator_capture_select_q <= comparator_capture_select_q;
      endcase
    end
  end

  // One holding register serves every upper-byte transfer. A write in the same
  // cycle as a lower-byte read wins, since software ordering cannot overlap them.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      temp_q <= `T16_RST_BYTE;
    end else if (wr_lo && (wreq_q.addr == `T16_OFF_COUNT_HI ||
                           wreq_q.addr == `T16_OFF_CAPT_HI)) begin
      temp_q <= wbyte;
    end else if (do_rd && s_axi_araddr_i == `T16_OFF_COUNT_LO) begin
      temp_q <= count_q[15:8];
    end else if (do_rd && s_axi_araddr_i == `T16_OFF_CAPT_LO) begin
      temp_q <= capt_q[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer clock selection

  logic ext_edge;
  logic cnt_tick;

  t16_trig_sync u_ext_clk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .filter_en_i(1'b0),
    .rising_i(ctrlb_q.clk_sel == `T16_CS_EXT_RISE),
    .enable_i(1'b1),
    .raw_i(external_clock_pin_i),
    .level_o(),
    .edge_o(ext_edge)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i || ctrlb_q.clk_sel == `T16_CS_STOP) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + `T16_PRE_ONE;
    end
  end

  always_comb begin
    case (ctrlb_q.clk_sel)
      `T16_CS_STOP: cnt_tick = 1'b0;
      `T16_CS_DIV1: cnt_tick = 1'b1;
      `T16_CS_DIV8: cnt_tick = (pre_q & `T16_PRE_M8) == `T16_PRE_M8;
      `T16_CS_DIV64: cnt_tick = (pre_q & `T16_PRE_M64) == `T16_PRE_M64;
      `T16_CS_DIV256: cnt_tick = (pre_q & `T16_PRE_M256) == `T16_PRE_M256;
      `T16_CS_DIV1024: cnt_tick = (pre_q & `T16_PRE_M1024) == `T16_PRE_M1024;
      default: cnt_tick = ext_edge;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter unit

  logic [15:0] top;
  logic at_top, at_bottom;
  logic cnt_clear, cnt_strobe, cnt_down;
  logic ovf_event;

  always_comb begin
    case (wgm)
      `T16_WGM_PC8, `T16_WGM_FP8: top = `T16_TOP8;
      `T16_WGM_PC9, `T16_WGM_FP9: top = `T16_TOP9;
      `T16_WGM_PC10, `T16_WGM_FP10: top = `T16_TOP10;
      `T16_WGM_PFC_ICR, `T16_WGM_PC_ICR, `T16_WGM_CTC_ICR, `T16_WGM_FP_ICR: top = capt_q;
      default: top = `T16_MAX;
    endcase
  end

  assign at_top = (count_q == top);
  assign at_bottom = (count_q == `T16_BOTTOM);

  // Direction turns at the ends of a dual-slope sequence.
  always_comb begin
    cnt_down = 1'b0;
    if (dual_slope(wgm)) begin
      cnt_down = at_top ? 1'b1 : (at_bottom ? 1'b0 : dir_down_q);
    end
  end

  assign cnt_strobe = cnt_tick;
  assign cnt_clear = cnt_tick & ~dual_slope(wgm) & at_top;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dir_down_q <= 1'b0;
    end else if (cnt_tick) begin
      dir_down_q <= cnt_down;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= `T16_RST_WORD;
    end else if (wr_lo && wreq_q.addr == `T16_OFF_COUNT_LO) begin
      count_q <= {temp_q, wbyte};
    end else if (cnt_clear) begin
      count_q <= `T16_RST_WORD;
    end else if (cnt_strobe) begin
      count_q <= cnt_down ? count_q - `T16_ONE : count_q + `T16_ONE;
    end
  end

  // Normal and clear-on-match modes overflow at MAX, fast PWM at its top,
  // dual-slope modes at bottom.
  always_comb begin
    if (dual_slope(wgm)) begin
      ovf_event = cnt_tick & at_bottom & dir_down_q;
    end else if (wgm == `T16_WGM_NORMAL || wgm == `T16_WGM_CTC_A ||
                 wgm == `T16_WGM_CTC_ICR) begin
      ovf_event = cnt_tick & (count_q == `T16_MAX);
    end else begin
      ovf_event = cnt_tick & at_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input capture

  logic trig_raw;
  logic capt_edge;
  logic capt_wr;

  // With comparator select clear, the pin input is what the edge detector sees, whether the outside world or
  // the port's own output drives it.
  assign trig_raw = comparator_capture_select_q ? comparator_output_i : capture_pin_i;

  t16_trig_sync u_capt_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .filter_en_i(ctrlb_q.noise_en),
    .rising_i(ctrlb_q.edge_rise),
    .enable_i(~capt_is_top(wgm)),
    .raw_i(trig_raw),
    .level_o(),
    .edge_o(capt_edge)
  );

  assign capt_wr = wr_lo && wreq_q.addr == `T16_OFF_CAPT_LO && capt_is_top(wgm);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      capt_q <= `T16_RST_WORD;
    end else if (capt_edge) begin
      capt_q <= count_q;
    end else if (capt_wr) begin
      capt_q <= {temp_q, wbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt requests

  logic flag_wr;
  assign flag_wr = wr_lo && wreq_q.addr == `T16_OFF_FLAG;

  // A set in the same cycle as a clear wins.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_q <= '0;
    end else begin
      if (ovf_event) begin
        flags_q.overflow <= 1'b1;
      end else if (overflow_irq_ack_i || (flag_wr && wbyte[`T16_OVF_BIT])) begin
        flags_q.overflow <= 1'b0;
      end
      if (capt_edge) begin
        flags_q.capture <= 1'b1;
      end else if (capture_irq_ack_i || (flag_wr && wbyte[`T16_CAP_BIT])) begin
        flags_q.capture <= 1'b0;
      end
    end
  end

  assign overflow_irq_o = flags_q.overflow & mask_q.overflow;
  assign capture_irq_o = flags_q.capture & mask_q.capture;

endmodule // t16_timer

`default_nettype wire

// ### sim/t16_timer_assertions.sv
// Port-level checks of the 16-bit timer, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module t16_timer_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // Triggers and interrupts
  input wire logic capture_pin_i,
  input wire logic comparator_output_i,
  input wire logic capture_irq_o,
  input wire logic capture_irq_ack_i,
  input wire logic overflow_irq_o
);
  logic [1:0] pins_q;
  logic [4:0] quiet_q;
  // Acks are judged only once no trigger edge can still be in the filter.
  always_ff @(posedge clk_i) begin
    pins_q <= {capture_pin_i, comparator_output_i};
    if (reset_i || pins_q != {capture_pin_i, comparator_output_i}) begin
      quiet_q <= 5'h00;
    end else if (quiet_q != 5'h1F) begin
      quiet_q <= quiet_q + 5'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  r_byte_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  ar_ready_a: assert property (s_axi_arready_o == !s_axi_rvalid_o)
    else $error("read address ready wrong");
  aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  r_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  b_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write answer timing");
  cap_ack_a: assert property (capture_irq_ack_i && quiet_q >= 5'h14 |=> !capture_irq_o)
    else $error("capture acknowledge did not clear");
  reset_out_a: assert property (disable iff (1'b0) reset_i |=> !s_axi_bvalid_o &&
    !s_axi_rvalid_o && !capture_irq_o && !overflow_irq_o) else $error("outputs not reset");
endmodule // t16_timer_assertions

bind t16_timer t16_timer_assertions t16_timer_assertions_i (.clk_i, .reset_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .capture_pin_i, .comparator_output_i, .capture_irq_o, .capture_irq_ack_i,
  .overflow_irq_o);
`default_nettype wire

// ### sim/t16_host.sv
// Bus master standing in for the processor core that reaches the timer registers.
`timescale 1ns/10ps
`default_nettype none
module t16_host (
  // Clock
  input wire logic clk_i,
  // Requests
  output logic awv_o,
  output logic [5:0] awa_o,
  output logic wv_o,
  output logic [31:0] wd_o,
  output logic [3:0] ws_o,
  output logic br_o,
  output logic arv_o,
  output logic [5:0] ara_o,
  output logic rr_o,
  // Answers
  input wire logic awr_i,
  input wire logic wr_i,
  input wire logic bv_i,
  input wire logic [1:0] bresp_i,
  input wire logic arr_i,
  input wire logic rv_i,
  input wire logic [31:0] rd_i,
  input wire logic [1:0] rresp_i
);
  initial begin
    {awv_o, wv_o, br_o, arv_o, rr_o} = 5'h00;
    {awa_o, ara_o, ws_o} = 16'h0000;
    wd_o = 32'h00000000;
  end
  // Random idle gaps make the slave meet both prompt and late requests.
  task automatic write(input logic [5:0] a, input logic [7:0] d, input logic s,
      output logic [1:0] resp);
    repeat ($urandom_range(2)) @(posedge clk_i);
    @(posedge clk_i);
    awv_o <= 1'b1;
    awa_o <= a;
    wv_o <= 1'b1;
    wd_o <= {24'h000000, d};
    ws_o <= {3'h0, s};
    br_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr_i) awv_o <= 1'b0;
      if (wr_i) wv_o <= 1'b0;
    end while (!bv_i);
    resp = bresp_i;
    br_o <= 1'b0;
  endtask
  task automatic read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
    repeat ($urandom_range(2)) @(posedge clk_i);
    @(posedge clk_i);
    arv_o <= 1'b1;
    ara_o <= a;
    rr_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arr_i) arv_o <= 1'b0;
    end while (!rv_i);
    d = rd_i;
    resp = rresp_i;
    rr_o <= 1'b0;
  endtask
endmodule // t16_host
`default_nettype wire

// ### sim/t16_timer_tb.sv
// Self-checking bench of the 16-bit timer against a byte-level register model.
`timescale 1ns/10ps
`default_nettype none
module t16_timer_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [5:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic external_clock_pin_i = 1'b0, capture_pin_i = 1'b0, comparator_output_i = 1'b0;
  logic overflow_irq_o, capture_irq_o, overflow_irq_ack_i = 1'b0, capture_irq_ack_i = 1'b0;
  int errors = 0, comparisons = 0, cyc = 0, n0, n1;
  logic [7:0] m [64];
  logic [15:0] cnt = 16'h0000, cap = 16'h0000;
  logic [7:0] hold = 8'h00;
  t16_timer t16_timer_i (.clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
    .s_axi_awprot_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
    .s_axi_rresp_o, .external_clock_pin_i, .capture_pin_i, .comparator_output_i,
    .overflow_irq_o, .overflow_irq_ack_i, .capture_irq_o, .capture_irq_ack_i);
  t16_host t16_host_i (.clk_i, .awv_o(s_axi_awvalid_i), .awa_o(s_axi_awaddr_i),
    .wv_o(s_axi_wvalid_i), .wd_o(s_axi_wdata_i), .ws_o(s_axi_wstrb_i), .br_o(s_axi_bready_i),
    .arv_o(s_axi_arvalid_i), .ara_o(s_axi_araddr_i), .rr_o(s_axi_rready_i),
    .awr_i(s_axi_awready_o), .wr_i(s_axi_wready_o), .bv_i(s_axi_bvalid_o),
    .bresp_i(s_axi_bresp_o), .arr_i(s_axi_arready_o), .rv_i(s_axi_rvalid_o),
    .rd_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] v);
    t16_host_i.write(a, v, 1'b1, rs);
    chk(rs, 2'h0);
    case (a)
      6'h0C, 6'h14: hold = v;
      6'h08: cnt = {hold, v};
      6'h10: if (m[4][4] && !m[0][0]) cap = {hold, v};
      6'h18: m[a] = m[a] & ~v;
      default: m[a] = v;
    endcase
  endtask
  task automatic r(input logic [5:0] a);
    logic [7:0] e;
    t16_host_i.read(a, d, rs);
    e = m[a];
    if (a == 6'h08) {hold, e} = cnt;
    if (a == 6'h10) {hold, e} = cap;
    if (a == 6'h0C || a == 6'h14) e = hold;
    chk(rs, 2'h0);
    chk(d, {24'h000000, e});
  endtask
  task automatic wc(input logic [15:0] v);
    w(6'h0C, v[15:8]);
    w(6'h08, v[7:0]);
  endtask
  task automatic pin(input logic p, input logic c);
    @(posedge clk_i);
    capture_pin_i <= p;
    comparator_output_i <= c;
  endtask
  task automatic ev();
    cap = cnt;
    m[6'h18][5] = 1'b1;
  endtask
  task automatic wirq(input logic e);
    for (int i = 0; i < 30 && capture_irq_o !== 1'b1; i++) @(posedge clk_i);
    chk(capture_irq_o, e);
  endtask
  // Capture delay is timed with the counter stopped, so the value is exact.
  task automatic lat(input logic [7:0] b, output int n);
    w(6'h04, b);
    pin(1'b1, 1'b0);
    for (n = 0; n < 40 && capture_irq_o !== 1'b1; n++) @(posedge clk_i);
    ev();
    r(6'h10);
    w(6'h18, 8'h20);
    pin(1'b0, 1'b0);
    wirq(1'b0);
  endtask
  initial begin
    void'($urandom(32'hB32C9FC9));
    foreach (m[i]) m[i] = 8'h00;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a <= 32; a += 4) r(6'(a));
    t16_host_i.read(6'h24, d, rs);
    chk({rs, d}, {2'h2, 32'h00000000});
    t16_host_i.write(6'h3C, 8'hFF, 1'b1, rs);
    chk(rs, 2'h2);
    t16_host_i.write(6'h04, 8'h07, 1'b0, rs);
    chk(rs, 2'h0);
    r(6'h04);
    repeat (4) begin
      wc(16'($urandom));
      r(6'h08);
      r(6'h0C);
    end
    w(6'h14, 8'hA5);
    w(6'h10, 8'h3C);
    w(6'h08, 8'h5A);
    r(6'h08);
    r(6'h0C);
    r(6'h10);
    r(6'h14);
    w(6'h1C, 8'h20);
    w(6'h04, 8'h40);
    pin(1'b1, 1'b0);
    wirq(1'b1);
    ev();
    r(6'h18);
    repeat (20) @(posedge clk_i);
    capture_irq_ack_i <= 1'b1;
    @(posedge clk_i) capture_irq_ack_i <= 1'b0;
    m[6'h18][5] = 1'b0;
    @(posedge clk_i);
    chk(capture_irq_o, 1'b0);
    pin(1'b0, 1'b0);
    wirq(1'b0);
    wc(16'($urandom));
    w(6'h04, 8'h00);
    pin(1'b1, 1'b0);
    wirq(1'b0);
    pin(1'b0, 1'b0);
    wirq(1'b1);
    ev();
    r(6'h10);
    r(6'h14);
    w(6'h04, 8'h40);
    w(6'h18, 8'h20);
    chk(capture_irq_o, 1'b0);
    w(6'h20, 8'h04);
    pin(1'b0, 1'b1);
    wirq(1'b1);
    ev();
    w(6'h18, 8'h20);
    pin(1'b1, 1'b1);
    wirq(1'b0);
    w(6'h20, 8'h00);
    pin(1'b0, 1'b0);
    wirq(1'b0);
    lat(8'h40, n0);
    lat(8'hC0, n1);
    chk(n1 - n0, 4);
    pin(1'b1, 1'b0);
    repeat (2) @(posedge clk_i);
    pin(1'b0, 1'b0);
    wirq(1'b0);
    w(6'h00, 8'h01);
    w(6'h04, 8'h58);
    w(6'h14, 8'hC3);
    w(6'h10, 8'h96);
    r(6'h10);
    w(6'h00, 8'h00);
    w(6'h10, 8'h96);
    r(6'h10);
    r(6'h14);
    pin(1'b1, 1'b0);
    wirq(1'b0);
    pin(1'b0, 1'b0);
    w(6'h04, 8'h40);
    wc(16'hFFF0);
    w(6'h1C, 8'h21);
    w(6'h04, 8'h41);
    for (int i = 0; i < 100 && overflow_irq_o !== 1'b1; i++) @(posedge clk_i);
    chk(overflow_irq_o, 1'b1);
    w(6'h04, 8'h40);
    m[6'h18][0] = 1'b1;
    r(6'h18);
    overflow_irq_ack_i <= 1'b1;
    @(posedge clk_i) overflow_irq_ack_i <= 1'b0;
    @(posedge clk_i);
    chk(overflow_irq_o, 1'b0);
    end_sim();
  end
endmodule // t16_timer_tb
`default_nettype wire
